//--- program_sequencer_and_stack_tb.sv
// self-checking bench for the program sequencer and stacks
`timescale 1ns/100ps
`include "psq_regs.svh"
module program_sequencer_and_stack_tb;
    import psq_pkg::*;

    // -------------------------------------------------------------
    // signals
    // -------------------------------------------------------------
    logic sys_clk, srst, step_valid;
    psq_step_s step;
    psq_sys_s sys;
    logic [11:0] indirect_target_reg, prog_counter;
    logic [6:0] dm_addr, gp_pointer;
    logic [3:0] sys_rdata, dm_col;
    logic [2:0] dm_row, stack_index;
    logic [10:0] gr_addr;
    logic [4:0] status_word;
    logic table_fetch, stack_fault;
    logic [15:0] transfer_buffer;
    int fails, num_checks, fault_cnt, fetch_cnt;
    logic [11:0] vec_tab [5];
    logic [11:0] ret_pc;

    psq_sequencer i_dut (
        .sys_clk(sys_clk), .srst(srst), .step_valid(step_valid),
        .step(step), .indirect_target_reg(indirect_target_reg),
        .sys(sys), .sys_rdata(sys_rdata), .dm_addr(dm_addr),
        .dm_row(dm_row), .dm_col(dm_col), .gr_addr(gr_addr),
        .prog_counter(prog_counter), .stack_index(stack_index),
        .status_word(status_word), .gp_pointer(gp_pointer),
        .table_fetch(table_fetch), .stack_fault(stack_fault)
    );

    psq_prog_mem_model i_mem (
        .sys_clk(sys_clk), .srst(srst), .prog_counter(prog_counter),
        .table_fetch(table_fetch), .transfer_buffer(transfer_buffer)
    );

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // pulses are counted so their exact cycle does not matter here
    always @(posedge sys_clk) begin
        if (stack_fault === 1'b1) fault_cnt++;
        if (table_fetch === 1'b1) fetch_cnt++;
    end

    // -------------------------------------------------------------
    // tasks
    // -------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // leaves step_valid high so steps can follow back to back
    task automatic do_step(input psq_op_e op, input logic [11:0] tgt,
                           input logic [2:0] src);
        @(negedge sys_clk);
        step_valid = 1'b1;
        step.op = op;
        step.target = tgt;
        step.irq_src = src;
        @(posedge sys_clk);
    endtask

    task automatic idle();
        @(negedge sys_clk);
        step_valid = 1'b0;
        @(posedge sys_clk);
        @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    task automatic chk_seq(input logic [11:0] pc, input logic [2:0] si);
        chk(prog_counter, pc);
        chk(stack_index, si);
    endtask

    task automatic sys_wr(input logic [6:0] a, input logic [3:0] d);
        @(negedge sys_clk);
        sys.wr = 1'b1;
        sys.addr = a;
        sys.wdata = d;
        @(posedge sys_clk);
        @(negedge sys_clk);
        sys.wr = 1'b0;
    endtask

    task automatic sys_rd(input logic [6:0] a, input logic [3:0] exp);
        @(negedge sys_clk);
        sys.rd = 1'b1;
        sys.addr = a;
        @(posedge sys_clk);
        @(negedge sys_clk);
        sys.rd = 1'b0;
        chk(sys_rdata, exp);
    endtask

    task automatic results();
        $display("checks=%0d mismatches=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        #400000;
        fails++;
        results();
    end

    // -------------------------------------------------------------
    // tests
    // -------------------------------------------------------------
    initial begin
        vec_tab = '{`PSQ_VEC_0, `PSQ_VEC_1, `PSQ_VEC_2, `PSQ_VEC_3,
                    `PSQ_VEC_4};
        fails = 0;
        num_checks = 0;
        fault_cnt = 0;
        fetch_cnt = 0;
        step_valid = 1'b0;
        step = '{op: PSQ_OP_NEXT, target: 12'h000, irq_src: 3'h0};
        sys = '0;
        indirect_target_reg = 12'h000;
        dm_addr = 7'h00;
        srst = 1'b1;
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        srst = 1'b0;
        chk_seq(12'h000, 3'h0);
        chk(status_word, 5'h00);
        chk(gp_pointer, 7'h00);
        do_step(PSQ_OP_NEXT, 12'h000, 3'h0);
        do_step(PSQ_OP_NEXT, 12'h000, 3'h0);
        idle();
        chk_seq(12'h002, 3'h0);
        do_step(PSQ_OP_JUMP, 12'habc, 3'h0);
        idle();
        chk_seq(12'habc, 3'h0);
        do_step(PSQ_OP_CALL, 12'hfff, 3'h0);
        idle();
        chk_seq(12'h7ff, 3'h1);
        do_step(PSQ_OP_RET, 12'h000, 3'h0);
        do_step(PSQ_OP_CALL, 12'h123, 3'h0);
        do_step(PSQ_OP_RET, 12'h000, 3'h0);
        idle();
        chk_seq(12'habe, 3'h0);
        // fill the address stack, overflow, then unwind past empty
        for (int i = 0; i < 6; i++) begin
            do_step(PSQ_OP_CALL, 12'h100 + 12'(i * 16), 3'h0);
            idle();
            chk_seq(12'h100 + 12'((i > 4 ? 4 : i) * 16),
                    3'(i > 4 ? 5 : i + 1));
        end
        chk(fault_cnt, 1);
        for (int i = 5; i >= 0; i--) begin
            ret_pc = (i == 0) ? 12'habf : (i == 1) ? 12'habf :
                     12'h0f1 + 12'((i - 1) * 16);
            do_step(PSQ_OP_RET, 12'h000, 3'h0);
            idle();
            chk_seq(ret_pc, 3'(i == 0 ? 0 : i - 1));
        end
        chk(fault_cnt, 2);
        do_step(psq_op_e'(10'h003), 12'h000, 3'h0);
        idle();
        chk_seq(12'habf, 3'h0);
        chk(fault_cnt, 3);
        // indirect loads and table reference
        indirect_target_reg = 12'hf12;
        do_step(PSQ_OP_JUMP_IND, 12'h000, 3'h0);
        idle();
        chk_seq(12'hf12, 3'h0);
        indirect_target_reg = 12'he34;
        do_step(PSQ_OP_CALL_IND, 12'h000, 3'h0);
        idle();
        chk_seq(12'he34, 3'h1);
        do_step(PSQ_OP_RET_SKIP, 12'h000, 3'h0);
        idle();
        chk_seq(12'hf14, 3'h0);
        indirect_target_reg = 12'hd56;
        do_step(PSQ_OP_TABLE, 12'h000, 3'h0);
        idle();
        chk_seq(12'hd56, 3'h1);
        chk(fetch_cnt, 1);
        chk(transfer_buffer, 16'h5d56);
        do_step(PSQ_OP_RET, 12'h000, 3'h0);
        idle();
        chk_seq(12'hf15, 3'h0);
        // pointer and status nibbles
        sys_wr(7'h7d, 4'h5);
        sys_wr(7'h7e, 4'hb);
        sys_wr(7'h7f, 4'ha);
        sys_wr(7'h10, 4'hf);
        chk(gp_pointer, 7'h2d);
        chk(status_word, 5'h1a);
        sys_rd(7'h7d, 4'h5);
        sys_rd(7'h7e, 4'hb);
        sys_rd(7'h7f, 4'ha);
        sys_rd(7'h10, 4'h0);
        dm_addr = 7'h1a;
        #1;
        chk(dm_row, 3'h1);
        chk(dm_col, 4'ha);
        chk(gr_addr, 11'h2da);
        // each source once, source code 7 falls back to source 0
        for (int s = 0; s < 6; s++) begin
            do_step(PSQ_OP_IRQ_ACK, 12'h000, 3'(s == 5 ? 7 : s));
            idle();
            chk_seq(vec_tab[s == 5 ? 0 : s], 3'h1);
            chk(status_word, 5'h00);
            do_step(PSQ_OP_RET_IRQ, 12'h000, 3'h0);
            idle();
            chk_seq(12'hf15, 3'h0);
            chk(status_word, 5'h1a);
        end
        // nest three interrupts, the fourth is refused
        for (int i = 0; i < 4; i++) begin
            sys_wr(7'h7f, 4'(i + 1));
            do_step(PSQ_OP_IRQ_ACK, 12'h000, 3'(i));
            idle();
            chk_seq(vec_tab[i > 2 ? 2 : i], 3'(i > 2 ? 3 : i + 1));
        end
        chk(fault_cnt, 4);
        for (int i = 2; i >= 0; i--) begin
            do_step(PSQ_OP_RET_IRQ, 12'h000, 3'h0);
            idle();
            chk_seq(i == 0 ? 12'hf15 : vec_tab[i - 1], 3'(i));
            chk(status_word, i == 0 ? 5'h11 : 5'(i + 1));
        end
        // back to back: acknowledge then return, indirect call then return
        do_step(PSQ_OP_IRQ_ACK, 12'h000, 3'h1);
        do_step(PSQ_OP_RET_IRQ, 12'h000, 3'h0);
        idle();
        chk_seq(12'hf15, 3'h0);
        chk(status_word, 5'h11);
        do_step(PSQ_OP_CALL_IND, 12'h000, 3'h0);
        do_step(PSQ_OP_RET, 12'h000, 3'h0);
        idle();
        chk_seq(12'hf16, 3'h0);
        results();
    end
endmodule

//--- psq_dm_split.sv
// data memory address split and general register address forming
`timescale 1ns/100ps
`include "psq_regs.svh"
module psq_dm_split (
    // operand address and pointer
    input wire logic [`PSQ_DM_AW-1:0] dm_addr,
    input wire logic [`PSQ_GPP_W-1:0] gp_pointer,
    // split results
    output logic [`PSQ_ROW_W-1:0] dm_row,
    output logic [`PSQ_COL_W-1:0] dm_col,
    output logic [`PSQ_GR_AW-1:0] gr_addr
);
    // upper bits are the row, lower the column
    assign dm_row = dm_addr[6:4];
    assign dm_col = dm_addr[3:0];
    // bank from the high pointer part, row from the low part
    assign gr_addr = {gp_pointer[6:3], gp_pointer[2:0], dm_addr[3:0]};
endmodule

//--- psq_pkg.sv
// types shared by the program sequencer files
package psq_pkg;

    // -------------------------------------------------------------
    // sequencing operations, one-hot
    // -------------------------------------------------------------
    typedef enum logic [9:0] {
        PSQ_OP_NEXT     = 10'h001,
        PSQ_OP_JUMP     = 10'h002,
        PSQ_OP_CALL     = 10'h004,
        PSQ_OP_JUMP_IND = 10'h008,
        PSQ_OP_CALL_IND = 10'h010,
        PSQ_OP_TABLE    = 10'h020,
        PSQ_OP_RET      = 10'h040,
        PSQ_OP_RET_SKIP = 10'h080,
        PSQ_OP_RET_IRQ  = 10'h100,
        PSQ_OP_IRQ_ACK  = 10'h200
    } psq_op_e;

    // -------------------------------------------------------------
    // carriers
    // -------------------------------------------------------------
    typedef struct packed {
        psq_op_e op;
        logic [11:0] target;
        logic [2:0] irq_src;
    } psq_step_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [3:0] wdata;
    } psq_sys_s;

endpackage

//--- psq_prog_mem_model.sv
// program memory model: answers table fetches into the transfer buffer
`timescale 1ns/100ps
module psq_prog_mem_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // fetch request from the sequencer
    input wire logic [11:0] prog_counter,
    input wire logic table_fetch,
    // constant word handed to the data side
    output logic [15:0] transfer_buffer
);
    // -------------------------------------------------------------
    // contents
    // -------------------------------------------------------------
    // every word carries its own address so a wrong fetch shows up
    logic [15:0] rom [4096];

    initial begin
        for (int i = 0; i < 4096; i++) begin
            rom[i] = {4'h5, 12'(i)};
        end
    end

    // -------------------------------------------------------------
    // fetch
    // -------------------------------------------------------------
    // the whole 12-bit range is decoded, no page folding here
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            transfer_buffer <= 16'h0000;
        end else if (table_fetch) begin
            transfer_buffer <= rom[prog_counter];
        end
    end
endmodule

//--- psq_regs.svh
// offsets, field positions, reset values and vectors of the sequencer
//
// Operation
// - counter advances unless a load occurs
// - program counter is 12-bit binary counter
// - reset clears program counter to zero
// - words 0000H-0005H hold reset and vectors
// - direct call reaches page 0 only
// - branch, indirect call, table reach everything
// - indirect ops load counter from address register
// - returns load counter from stack top
// - interrupt acknowledge loads fixed vector address
// - 3-bit pointer, five address, three status slots
// - call and table read push return address
// - interrupt saves address, status; clears status
// - 7-bit address: 3 row, 4 column
// - register pointer spans 7DH and 7EH upper
// - high pointer part bank, low part row
// - status word in 7EH bit0 and 7FH
`ifndef PSQ_REGS_SVH
`define PSQ_REGS_SVH

// -----------------------------------------------------------------
// widths
// -----------------------------------------------------------------
`define PSQ_PC_W 12
`define PSQ_PAGE_W 11
`define PSQ_RSLOT_N 5
`define PSQ_ISR_N 3
`define PSQ_SP_W 3
`define PSQ_PSW_W 5
`define PSQ_DM_AW 7
`define PSQ_ROW_W 3
`define PSQ_COL_W 4
`define PSQ_NIB_W 4
`define PSQ_GPP_W 7
`define PSQ_GR_AW 11

// -----------------------------------------------------------------
// system register nibble offsets and fields
// -----------------------------------------------------------------
`define PSQ_OFF_GPP_BANK 7'h7d
`define PSQ_OFF_GPP_ROW 7'h7e
`define PSQ_OFF_PSW_LO 7'h7f
`define PSQ_BCD_BIT 0

// -----------------------------------------------------------------
// reset values and vectors
// -----------------------------------------------------------------
`define PSQ_PC_RST 12'h000
`define PSQ_SP_RST 3'h0
`define PSQ_ISP_RST 2'h0
`define PSQ_GPP_RST 7'h00
`define PSQ_PSW_RST 5'h00
`define PSQ_VEC_0 12'h005
`define PSQ_VEC_1 12'h004
`define PSQ_VEC_2 12'h003
`define PSQ_VEC_3 12'h002
`define PSQ_VEC_4 12'h001

`endif

//--- psq_sequencer.sv
// program counter, stacks and pointer registers of the 4-bit core
`timescale 1ns/100ps
`include "psq_regs.svh"
module psq_sequencer
    import psq_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // instruction step from decode
    input wire logic step_valid,
    input wire psq_step_s step,
    input wire logic [`PSQ_PC_W-1:0] indirect_target_reg,
    // system register nibble access
    input wire psq_sys_s sys,
    output logic [`PSQ_NIB_W-1:0] sys_rdata,
    // data memory addressing
    input wire logic [`PSQ_DM_AW-1:0] dm_addr,
    output logic [`PSQ_ROW_W-1:0] dm_row,
    output logic [`PSQ_COL_W-1:0] dm_col,
    output logic [`PSQ_GR_AW-1:0] gr_addr,
    // sequencer state
    output logic [`PSQ_PC_W-1:0] prog_counter,
    output logic [`PSQ_SP_W-1:0] stack_index,
    output logic [`PSQ_PSW_W-1:0] status_word,
    output logic [`PSQ_GPP_W-1:0] gp_pointer,
    output logic table_fetch,
    output logic stack_fault
);

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    logic [`PSQ_PC_W-1:0] pc_q, pc_d;
    logic [`PSQ_SP_W-1:0] sp_q, sp_d;
    logic [1:0] isp_q, isp_d;
    logic [`PSQ_PSW_W-1:0] psw_q, psw_d;
    logic [`PSQ_GPP_W-1:0] gpp_q, gpp_d;
    logic [`PSQ_NIB_W-1:0] rdata_q, rdata_d;
    logic tbl_q, tbl_d;
    logic fault_q, fault_d;

    logic push;
    logic ipush;
    logic [`PSQ_PC_W-1:0] push_data;
    logic rs_full, rs_empty, isr_full, isr_empty;
    logic [`PSQ_SP_W-1:0] sp_m1;
    logic [1:0] isp_m1;
    logic [`PSQ_PC_W-1:0] rs_rd [`PSQ_RSLOT_N];
    logic [`PSQ_PSW_W-1:0] isr_rd [`PSQ_ISR_N];
    logic [`PSQ_PC_W-1:0] rs_top;
    logic [`PSQ_PSW_W-1:0] isr_top;

    // vector table sits inside the reserved low words
    function automatic logic [`PSQ_PC_W-1:0] vec_of(
        input logic [2:0] src
    );
        logic [`PSQ_PC_W-1:0] v;
        v = `PSQ_VEC_0;
        case (src)
            3'h1: v = `PSQ_VEC_1;
            3'h2: v = `PSQ_VEC_2;
            3'h3: v = `PSQ_VEC_3;
            3'h4: v = `PSQ_VEC_4;
            default: v = `PSQ_VEC_0;
        endcase
        return v;
    endfunction

    // -------------------------------------------------------------
    // stack slots
    // -------------------------------------------------------------
    // five address slots and three status slots
    for (genvar i = 0; i < `PSQ_RSLOT_N; i++) begin : g_rs
        psq_slot #(.W(`PSQ_PC_W)) u_slot (
            .sys_clk(sys_clk),
            .srst(srst),
            .wr_en(push && (sp_q == 3'(i))),
            .wr_data(push_data),
            .rd_data(rs_rd[i])
        );
    end

    for (genvar j = 0; j < `PSQ_ISR_N; j++) begin : g_isr
        psq_slot #(.W(`PSQ_PSW_W)) u_slot (
            .sys_clk(sys_clk),
            .srst(srst),
            .wr_en(ipush && (isp_q == 2'(j))),
            .wr_data(psw_q),
            .rd_data(isr_rd[j])
        );
    end

    assign sp_m1 = sp_q - 3'h1;
    assign isp_m1 = isp_q - 2'h1;
    assign rs_full = (sp_q == 3'(`PSQ_RSLOT_N));
    assign rs_empty = (sp_q == 3'h0);
    assign isr_full = (isp_q == 2'(`PSQ_ISR_N));
    assign isr_empty = (isp_q == 2'h0);
    // pointer never leaves 0..5, so the index stays in range
    assign rs_top = rs_empty ? '0 : rs_rd[sp_m1];
    assign isr_top = isr_empty ? '0 : isr_rd[isp_m1];

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    always_comb begin
        pc_d = pc_q;
        sp_d = sp_q;
        isp_d = isp_q;
        psw_d = psw_q;
        gpp_d = gpp_q;
        push = 1'b0;
        ipush = 1'b0;
        push_data = pc_q + 12'h001;
        tbl_d = 1'b0;
        fault_d = 1'b0;
        // software writes first, so that acknowledge and return win
        if (sys.wr) begin
            if (sys.addr == `PSQ_OFF_GPP_BANK) begin
                gpp_d[6:3] = sys.wdata;
            end else if (sys.addr == `PSQ_OFF_GPP_ROW) begin
                gpp_d[2:0] = sys.wdata[3:1];
                psw_d[4] = sys.wdata[`PSQ_BCD_BIT];
            end else if (sys.addr == `PSQ_OFF_PSW_LO) begin
                psw_d[3:0] = sys.wdata;
            end
        end
        if (step_valid) begin
            unique case (step.op)
                PSQ_OP_NEXT: begin
                    pc_d = pc_q + 12'h001;
                end
                PSQ_OP_JUMP: begin
                    pc_d = step.target;
                end
                PSQ_OP_CALL: begin
                    if (rs_full) begin
                        fault_d = 1'b1;
                    end else begin
                        push = 1'b1;
                        sp_d = sp_q + 3'h1;
                        pc_d = {1'b0, step.target[10:0]};
                    end
                end
                PSQ_OP_JUMP_IND: begin
                    pc_d = indirect_target_reg;
                end
                PSQ_OP_CALL_IND, PSQ_OP_TABLE: begin
                    if (rs_full) begin
                        fault_d = 1'b1;
                    end else begin
                        push = 1'b1;
                        sp_d = sp_q + 3'h1;
                        pc_d = indirect_target_reg;
                        tbl_d = (step.op == PSQ_OP_TABLE);
                    end
                end
                PSQ_OP_RET, PSQ_OP_RET_SKIP: begin
                    if (rs_empty) begin
                        fault_d = 1'b1;
                    end else begin
                        sp_d = sp_m1;
                        pc_d = rs_top;
                        if (step.op == PSQ_OP_RET_SKIP) begin
                            pc_d = rs_top + 12'h001;
                        end
                    end
                end
                PSQ_OP_RET_IRQ: begin
                    if (rs_empty || isr_empty) begin
                        fault_d = 1'b1;
                    end else begin
                        sp_d = sp_m1;
                        isp_d = isp_m1;
                        pc_d = rs_top;
                        psw_d = isr_top;
                    end
                end
                PSQ_OP_IRQ_ACK: begin
                    if (rs_full || isr_full) begin
                        fault_d = 1'b1;
                    end else begin
                        // the acknowledged slot replaces the step at pc
                        push = 1'b1;
                        push_data = pc_q;
                        ipush = 1'b1;
                        sp_d = sp_q + 3'h1;
                        isp_d = isp_q + 2'h1;
                        psw_d = `PSQ_PSW_RST;
                        pc_d = vec_of(step.irq_src);
                    end
                end
                default: begin
                    fault_d = 1'b1;
                end
            endcase
        end
    end

    // nibble readback; unmapped offsets read zero
    always_comb begin
        rdata_d = rdata_q;
        if (sys.rd) begin
            case (sys.addr)
                `PSQ_OFF_GPP_BANK: rdata_d = gpp_q[6:3];
                `PSQ_OFF_GPP_ROW: rdata_d = {gpp_q[2:0], psw_q[4]};
                `PSQ_OFF_PSW_LO: rdata_d = psw_q[3:0];
                default: rdata_d = 4'h0;
            endcase
        end
    end

    // -------------------------------------------------------------
    // registers
    // -------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pc_q <= `PSQ_PC_RST;
            sp_q <= `PSQ_SP_RST;
            isp_q <= `PSQ_ISP_RST;
            psw_q <= `PSQ_PSW_RST;
            gpp_q <= `PSQ_GPP_RST;
            rdata_q <= 4'h0;
            tbl_q <= 1'b0;
            fault_q <= 1'b0;
        end else begin
            pc_q <= pc_d;
            sp_q <= sp_d;
            isp_q <= isp_d;
            psw_q <= psw_d;
            gpp_q <= gpp_d;
            rdata_q <= rdata_d;
            tbl_q <= tbl_d;
            fault_q <= fault_d;
        end
    end

    assign prog_counter = pc_q;
    assign stack_index = sp_q;
    assign status_word = psw_q;
    assign gp_pointer = gpp_q;
    assign sys_rdata = rdata_q;
    assign table_fetch = tbl_q;
    assign stack_fault = fault_q;

    psq_dm_split u_split (
        .dm_addr(dm_addr),
        .gp_pointer(gpp_q),
        .dm_row(dm_row),
        .dm_col(dm_col),
        .gr_addr(gr_addr)
    );

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    chk_pc_advance: assert property (@(posedge sys_clk) disable iff (srst)
        step_valid && step.op == PSQ_OP_NEXT
        |=> prog_counter == $past(prog_counter) + 12'h001)
        else $error("counter did not advance");

    chk_pc_reset: assert property (@(posedge sys_clk)
        srst |=> prog_counter == 12'h000 && stack_index == 3'h0)
        else $error("reset did not clear counter");

    chk_call_page: assert property (@(posedge sys_clk) disable iff (srst)
        step_valid && step.op == PSQ_OP_CALL && !rs_full
        |=> prog_counter == {1'b0, $past(step.target[10:0])}
        && stack_index == $past(stack_index) + 3'h1)
        else $error("direct call left page zero");

    chk_jump_full: assert property (@(posedge sys_clk) disable iff (srst)
        step_valid && step.op == PSQ_OP_JUMP
        |=> prog_counter == $past(step.target))
        else $error("branch target wrong");

    chk_indirect_load: assert property (@(posedge sys_clk)
        disable iff (srst)
        step_valid && step.op == PSQ_OP_TABLE && !rs_full
        |=> prog_counter == $past(indirect_target_reg) && table_fetch
        ##1 !table_fetch)
        else $error("table read did not load address register");

    chk_call_return: assert property (@(posedge sys_clk)
        disable iff (srst)
        step_valid && step.op == PSQ_OP_CALL_IND && !rs_full
        ##1 step_valid && step.op == PSQ_OP_RET
        |=> prog_counter == $past(prog_counter, 2) + 12'h001
        && stack_index == $past(stack_index, 2))
        else $error("return did not pop the pushed address");

    chk_irq_vector: assert property (@(posedge sys_clk) disable iff (srst)
        step_valid && step.op == PSQ_OP_IRQ_ACK && !rs_full && !isr_full
        |=> prog_counter <= 12'h005 && prog_counter != 12'h000
        && status_word == 5'h00)
        else $error("interrupt vector or status clear wrong");

    chk_irq_restore: assert property (@(posedge sys_clk)
        disable iff (srst)
        step_valid && step.op == PSQ_OP_IRQ_ACK && !rs_full && !isr_full
        ##1 step_valid && step.op == PSQ_OP_RET_IRQ
        |=> status_word == $past(status_word, 2)
        && prog_counter == $past(prog_counter, 2))
        else $error("interrupt return did not restore state");

    chk_stack_range: assert property (@(posedge sys_clk)
        disable iff (srst)
        stack_index <= 3'h5 && isp_q <= 2'h3)
        else $error("stack pointer out of range");

    chk_rp_write: assert property (@(posedge sys_clk) disable iff (srst)
        sys.wr && sys.addr == 7'h7e
        |=> gp_pointer[2:0] == $past(sys.wdata[3:1]))
        else $error("register pointer row not written");

endmodule

//--- psq_slot.sv
// one stack slot: a loadable register
`timescale 1ns/100ps
module psq_slot #(
    parameter int W = 12
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // load side
    input wire logic wr_en,
    input wire logic [W-1:0] wr_data,
    // read side
    output logic [W-1:0] rd_data
);
    logic [W-1:0] val_q;
    logic [W-1:0] val_d;

    always_comb begin
        val_d = val_q;
        if (wr_en) begin
            val_d = wr_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            val_q <= '0;
        end else begin
            val_q <= val_d;
        end
    end

    assign rd_data = val_q;
endmodule
